// file: tlirq_arb.sv
// Two-level fixed-order arbiter over a set of masked requests.
module tlirq_arb #(
  parameter int N = 15,
  parameter int W = 4
) (
  // Requests and their levels.
  input  wire logic [N-1:0] i_req,
  input  wire logic [N-1:0] i_high,
  // Winner.
  output logic              o_valid,
  output logic [W-1:0]      o_index,
  output logic              o_high
);

  generate
    if (N < 1 || (1 << W) < N) begin : g_bad
      $error("tlirq_arb: index width cannot hold N");
    end
  endgenerate

  logic [N-1:0] hi_req;
  logic [N-1:0] pick;

  always_comb begin
    hi_req = i_req & i_high;
    pick   = (|hi_req) ? hi_req : i_req;
    o_valid = |i_req;
    o_high  = |hi_req;
    o_index = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (pick[k]) begin
        o_index = W'(k);
      end
    end
  end

endmodule

// file: tlirq_core_model.sv
// Behavioural core that marks instruction boundaries and completes returns.
module tlirq_core_model (
  // Clock and reset.
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // Bench commands.
  input  wire logic i_slow,
  input  wire logic i_ret_req,
  // Handshake towards the controller.
  output logic      o_insn_end,
  output logic      o_return_from_service
);
  logic [1:0] phase;
  logic [1:0] next_phase;
  always_comb begin
    next_phase = phase + 2'h1;
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end
  // A slow core ends an instruction only every fourth clock, as a long divide does.
  assign o_insn_end            = !i_ret_req && (!i_slow || phase == 2'h0);
  assign o_return_from_service = i_ret_req;
endmodule

// file: tlirq_ctrl.sv
// Two-level interrupt controller: enable and level registers, arbitration, vectoring and nesting.
`include "tlirq_map.svh"

module tlirq_ctrl #(
  parameter int NUM_SOURCES = `TLIRQ_NUM_SOURCES,
  parameter int CALL_CYCLES = `TLIRQ_CALL_CYCLES
) (
  // Clock and reset.
  input  wire logic                    i_clock,
  input  wire logic                    i_reset_n,
  // Special function register port.
  input  wire tlirq_pkg::tlirq_sfr_req_t i_sfr,
  output tlirq_pkg::tlirq_sfr_rsp_t    o_sfr,
  // Pending flags and extended enables and levels from elsewhere.
  input  wire tlirq_pkg::tlirq_flags_t i_flags,
  input  wire logic [7:0]              i_ext_mask,
  input  wire logic [7:0]              i_ext_level,
  // Core handshake.
  input  wire logic                    i_insn_end,
  input  wire logic                    i_return_from_service,
  output logic                         o_long_call,
  output logic [15:0]                  o_vector,
  output logic                         o_service_entry,
  output logic [`TLIRQ_NUM_HW_CLEAR-1:0] o_hw_clear,
  // Status.
  output logic [1:0]                   o_active_levels
);
  import tlirq_pkg::*;

  localparam int IDX_W = 4;
  localparam int CNT_W = 3;

  generate
    if (NUM_SOURCES != `TLIRQ_NUM_SOURCES) begin : g_bad_src
      $error("tlirq_ctrl: source count must match the flag layout");
    end
    if (CALL_CYCLES < 1 || CALL_CYCLES > 7) begin : g_bad_call
      $error("tlirq_ctrl: call length must fit the cycle counter");
    end
  endgenerate

  // Register state.
  logic [7:0] irq_mask_enable;
  logic [7:0] irq_level_select;
  logic [7:0] next_irq_mask_enable;
  logic [7:0] next_irq_level_select;
  tlirq_sfr_rsp_t next_sfr;

  logic global_irq_gate;
  logic serial_periph_mask;
  logic timer_two_mask;
  logic async_serial_mask;
  logic timer_one_mask;
  logic ext_pin_one_mask;
  logic timer_zero_mask;
  logic ext_pin_zero_mask;

  assign global_irq_gate    = irq_mask_enable[`TLIRQ_GATE_BIT];
  assign serial_periph_mask = irq_mask_enable[6];
  assign timer_two_mask     = irq_mask_enable[5];
  assign async_serial_mask  = irq_mask_enable[4];
  assign timer_one_mask     = irq_mask_enable[3];
  assign ext_pin_one_mask   = irq_mask_enable[2];
  assign timer_zero_mask    = irq_mask_enable[1];
  assign ext_pin_zero_mask  = irq_mask_enable[0];

  // Register writes: byte writes and single-bit writes, byte write first, bit write last.
  always_comb begin
    next_irq_mask_enable  = irq_mask_enable;
    next_irq_level_select = irq_level_select;
    if (i_sfr.wr_en && i_sfr.addr == `TLIRQ_ADDR_MASK_ENABLE) begin
      next_irq_mask_enable = i_sfr.wdata;
    end
    if (i_sfr.wr_en && i_sfr.addr == `TLIRQ_ADDR_LEVEL_SELECT) begin
      next_irq_level_select = i_sfr.wdata;
    end
    if (i_sfr.bit_wr_en) begin
      if (i_sfr.bit_addr[`TLIRQ_BIT_BASE_MSB:`TLIRQ_BIT_BASE_LSB] ==
          `TLIRQ_ADDR_MASK_ENABLE >> `TLIRQ_BIT_BASE_LSB) begin
        next_irq_mask_enable[i_sfr.bit_addr[2:0]] = i_sfr.bit_val;
      end
      if (i_sfr.bit_addr[`TLIRQ_BIT_BASE_MSB:`TLIRQ_BIT_BASE_LSB] ==
          `TLIRQ_ADDR_LEVEL_SELECT >> `TLIRQ_BIT_BASE_LSB) begin
        next_irq_level_select[i_sfr.bit_addr[2:0]] = i_sfr.bit_val;
      end
    end
    next_irq_level_select[`TLIRQ_LEVEL_FIXED_BIT] = 1'b1;
    next_sfr.hit   = 1'b0;
    next_sfr.rdata = 8'h00;
    if (i_sfr.rd_en && i_sfr.addr == `TLIRQ_ADDR_MASK_ENABLE) begin
      next_sfr.hit   = 1'b1;
      next_sfr.rdata = irq_mask_enable;
    end
    if (i_sfr.rd_en && i_sfr.addr == `TLIRQ_ADDR_LEVEL_SELECT) begin
      next_sfr.hit   = 1'b1;
      next_sfr.rdata = irq_level_select;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_mask_enable  <= `TLIRQ_RST_MASK_ENABLE;
      irq_level_select <= `TLIRQ_RST_LEVEL_SELECT;
      o_sfr            <= '0;
    end else begin
      irq_mask_enable  <= next_irq_mask_enable;
      irq_level_select <= next_irq_level_select;
      o_sfr            <= next_sfr;
    end
  end

  // Request masking. Flags come from same-clock peripheral logic; a flag that software
  // set is indistinguishable from one hardware set, and flags are taken as levels.
  logic [NUM_SOURCES-1:0] raw_req;
  logic [NUM_SOURCES-1:0] src_mask;
  logic [NUM_SOURCES-1:0] src_high;
  logic [NUM_SOURCES-1:0] masked_req;

  always_comb begin
    raw_req = {i_flags.extended,
               i_flags.serial_periph,
               i_flags.timer_two_low_overflow | i_flags.timer_two_high_overflow,
               i_flags.async_serial,
               i_flags.timer_one,
               i_flags.ext_pin_one,
               i_flags.timer_zero,
               i_flags.ext_pin_zero};
    src_mask = {i_ext_mask, irq_mask_enable[6:0]};
    src_high = {i_ext_level, irq_level_select[6:0]};
    masked_req = raw_req & src_mask & {NUM_SOURCES{global_irq_gate}};
  end

  logic             arb_valid;
  logic [IDX_W-1:0] arb_index;
  logic             arb_high;

  tlirq_arb #(
    .N (NUM_SOURCES),
    .W (IDX_W)
  ) u_arb (
    .i_req   (masked_req),
    .i_high  (src_high),
    .o_valid (arb_valid),
    .o_index (arb_index),
    .o_high  (arb_high)
  );

  // Detect stage: the decoded winner is registered every clock.
  logic             cand_valid;
  logic [IDX_W-1:0] cand_index;
  logic             cand_high;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cand_valid <= 1'b0;
      cand_index <= '0;
      cand_high  <= 1'b0;
    end else begin
      cand_valid <= arb_valid;
      cand_index <= arb_index;
      cand_high  <= arb_high;
    end
  end

  // Vectoring and nesting control.
  tlirq_state_t     state;
  tlirq_state_t     next_state;
  logic [CNT_W-1:0] call_cnt;
  logic [CNT_W-1:0] next_call_cnt;
  logic             active_low;
  logic             active_high;
  logic             next_active_low;
  logic             next_active_high;
  logic [IDX_W-1:0] taken_index;
  logic [IDX_W-1:0] next_taken_index;
  logic             taken_high;
  logic             next_taken_high;
  logic             next_long_call;
  logic [15:0]      next_vector;
  logic             next_service_entry;
  logic [`TLIRQ_NUM_HW_CLEAR-1:0] next_hw_clear;
  logic             may_take;

  always_comb begin
    // A high request preempts only a low routine; anything waits behind a high one.
    may_take = cand_valid && !active_high && (cand_high || !active_low);
    next_state         = state;
    next_call_cnt      = call_cnt;
    next_active_low    = active_low;
    next_active_high   = active_high;
    next_taken_index   = taken_index;
    next_taken_high    = taken_high;
    next_long_call     = 1'b0;
    next_vector        = o_vector;
    next_service_entry = 1'b0;
    next_hw_clear      = '0;
    case (state)
      TLIRQ_IDLE: begin
        if (i_return_from_service) begin
          if (active_high) begin
            next_active_high = 1'b0;
          end else begin
            next_active_low = 1'b0;
          end
          next_state = TLIRQ_POST;
        end else if (may_take && i_insn_end) begin
          next_state       = TLIRQ_CALL;
          next_call_cnt    = CNT_W'(CALL_CYCLES - 1);
          next_taken_index = cand_index;
          next_taken_high  = cand_high;
          next_long_call   = 1'b1;
          next_vector      = `TLIRQ_VECTOR_BASE +
                             (16'(cand_index) << `TLIRQ_VECTOR_STEP_SHIFT);
          if (cand_index < IDX_W'(`TLIRQ_NUM_HW_CLEAR)) begin
            next_hw_clear[cand_index[1:0]] = 1'b1;
          end
        end
      end
      TLIRQ_CALL: begin
        if (call_cnt == '0) begin
          next_state         = TLIRQ_IDLE;
          next_service_entry = 1'b1;
          if (taken_high) begin
            next_active_high = 1'b1;
          end else begin
            next_active_low = 1'b1;
          end
        end else begin
          next_call_cnt  = call_cnt - 1'b1;
          next_long_call = 1'b1;
        end
      end
      TLIRQ_POST: begin
        // One instruction must complete after a return before any new call.
        if (i_insn_end) begin
          next_state = TLIRQ_IDLE;
        end
      end
      default: begin
        next_state = TLIRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state           <= TLIRQ_IDLE;
      call_cnt        <= '0;
      active_low      <= 1'b0;
      active_high     <= 1'b0;
      taken_index     <= '0;
      taken_high      <= 1'b0;
      o_long_call     <= 1'b0;
      o_vector        <= `TLIRQ_RESET_VECTOR;
      o_service_entry <= 1'b0;
      o_hw_clear      <= '0;
    end else begin
      state           <= next_state;
      call_cnt        <= next_call_cnt;
      active_low      <= next_active_low;
      active_high     <= next_active_high;
      taken_index     <= next_taken_index;
      taken_high      <= next_taken_high;
      o_long_call     <= next_long_call;
      o_vector        <= next_vector;
      o_service_entry <= next_service_entry;
      o_hw_clear      <= next_hw_clear;
    end
  end

  assign o_active_levels = {active_high, active_low};

endmodule

// file: tlirq_ctrl_bench.sv
// Self-checking bench for the two-level interrupt controller.
`include "tlirq_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tlirq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tlirq_pkg::*;
  typedef struct packed {logic [7:0] me, lv, em, el; logic [15:0] fl, vec; logic [3:0] hc;} tlirq_row_t;
  localparam tlirq_row_t ROWS [10] = '{
    '{8'h81, 8'h00, 8'h00, 8'h00, 16'h0001, 16'h0003, 4'h1},
    '{8'hff, 8'h00, 8'h00, 8'h00, 16'h0006, 16'h000b, 4'h2},
    '{8'hff, 8'h04, 8'h00, 8'h00, 16'h0006, 16'h0013, 4'h4},
    '{8'ha0, 8'h00, 8'h00, 8'h00, 16'h0020, 16'h002b, 4'h0},
    '{8'ha0, 8'h20, 8'h00, 8'h00, 16'h0040, 16'h002b, 4'h0},
    '{8'hc0, 8'h00, 8'h00, 8'h00, 16'h0080, 16'h0033, 4'h0},
    '{8'h98, 8'h00, 8'h00, 8'h00, 16'h0018, 16'h001b, 4'h8},
    '{8'h98, 8'h10, 8'h00, 8'h00, 16'h0018, 16'h0023, 4'h0},
    '{8'h80, 8'h00, 8'h81, 8'h00, 16'h8100, 16'h003b, 4'h0},
    '{8'h81, 8'h00, 8'h80, 8'h80, 16'h8001, 16'h0073, 4'h0}};
  logic           i_clock, rn, slow, rq, insn, retn, lc, se;
  tlirq_sfr_req_t sfr;
  tlirq_sfr_rsp_t rsp;
  tlirq_flags_t   fl;
  logic [7:0]     em, el;
  logic [15:0]    vec;
  logic [3:0]     hc;
  logic [1:0]     act;
  int             n_mismatch = 0;
  int             n_tests = 0;
  tlirq_ctrl i_tlirq_ctrl (.i_clock(i_clock), .i_reset_n(rn), .i_sfr(sfr), .o_sfr(rsp), .i_flags(fl),
    .i_ext_mask(em), .i_ext_level(el), .i_insn_end(insn), .i_return_from_service(retn), .o_long_call(lc),
    .o_vector(vec), .o_service_entry(se), .o_hw_clear(hc), .o_active_levels(act));
  tlirq_core_model i_tlirq_core_model (.i_clock(i_clock), .i_reset_n(rn), .i_slow(slow), .i_ret_req(rq),
    .o_insn_end(insn), .o_return_from_service(retn));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) sfr <= '{1'b1, 1'b0, a, d, 1'b0, 8'h00, 1'b0};
    @(posedge i_clock) sfr <= '0;
  endtask
  task automatic bwr(input logic [7:0] ba, input logic v);
    @(posedge i_clock) sfr <= '{1'b0, 1'b0, 8'h00, 8'h00, 1'b1, ba, v};
    @(posedge i_clock) sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge i_clock) sfr <= '{1'b0, 1'b1, a, 8'h00, 1'b0, 8'h00, 1'b0};
    @(posedge i_clock) sfr <= '0;
    #1;
    `CHK(rsp, e)
  endtask
  task automatic svc(input logic [15:0] v, input logic [3:0] h, input int tc);
    int t;
    t = 0;
    while (lc !== 1'b1 && t < 40) begin
      @(posedge i_clock);
      #1;
      t++;
    end
    `CHK(lc, 1'b1)
    if (tc > 0) `CHK(t, tc)
    `CHK(vec, v)
    `CHK(hc, h)
    repeat (`TLIRQ_CALL_CYCLES) @(posedge i_clock);
    #1;
    `CHK(se, 1'b1)
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge i_clock);
      #1;
      `CHK(lc, 1'b0)
    end
  endtask
  task automatic ret(input logic [15:0] f);
    @(posedge i_clock) fl <= f;
    rq <= 1'b1;
    @(posedge i_clock) rq <= 1'b0;
  endtask
  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    summarize;
  end
  initial begin
    {rn, slow, rq, sfr, fl, em, el} = '0;
    repeat (8) @(posedge i_clock);
    rn <= 1'b1;
    foreach (ROWS[k]) begin
      wr(8'ha8, ROWS[k].me);
      wr(8'hb8, ROWS[k].lv);
      em <= ROWS[k].em;
      el <= ROWS[k].el;
      fl <= ROWS[k].fl;
      svc(ROWS[k].vec, ROWS[k].hc, 1 + `TLIRQ_DETECT_CYCLES);
      // Software clears every flag, the serial bus flag included, before it returns.
      ret(16'h0000);
    end
    wr(8'hb8, 8'h00);
    wr(8'ha8, 8'h01);
    fl <= 16'h0001;
    quiet(8);
    wr(8'ha8, 8'h80);
    quiet(8);
    bwr(8'ha8, 1'b1);
    svc(16'h0003, 4'h1, 0);
    ret(16'h0000);
    wr(8'ha8, 8'h87);
    wr(8'hb8, 8'h04);
    fl <= 16'h0002;
    svc(16'h000b, 4'h2, 0);
    @(posedge i_clock) fl <= 16'h0005;
    svc(16'h0013, 4'h4, 0);
    @(posedge i_clock) fl <= 16'h0001;
    quiet(8);
    ret(16'h0001);
    quiet(8);
    slow <= 1'b1;
    ret(16'h0001);
    svc(16'h0003, 4'h1, 0);
    ret(16'h0000);
    @(posedge i_clock) rn <= 1'b0;
    repeat (8) @(posedge i_clock);
    rn <= 1'b1;
    rd(8'ha8, 9'h100);
    rd(8'hb8, 9'h180);
    wr(8'hb8, 8'h00);
    rd(8'hb8, 9'h180);
    bwr(8'hba, 1'b1);
    rd(8'hb8, 9'h184);
    rd(8'ha8, 9'h100);
    rd(8'h99, 9'h000);
    summarize;
  end
endmodule

// file: tlirq_ctrl_properties.sv
// Concurrent checks on the interrupt controller ports.
`include "tlirq_map.svh"
module tlirq_ctrl_properties #(
  parameter int NUM_SOURCES = 15,
  parameter int CALL_CYCLES = 4
) (
  input wire logic                      i_clock,
  input wire logic                      i_reset_n,
  input wire tlirq_pkg::tlirq_sfr_req_t i_sfr,
  input wire tlirq_pkg::tlirq_sfr_rsp_t o_sfr,
  input wire logic                      i_return_from_service,
  input wire logic                      i_insn_end,
  input wire logic                      o_long_call,
  input wire logic [15:0]               o_vector,
  input wire logic                      o_service_entry,
  input wire logic [`TLIRQ_NUM_HW_CLEAR-1:0] o_hw_clear,
  input wire logic [1:0]                o_active_levels
);
  import tlirq_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  AST_CALL_LEN: assert property ($rose(o_long_call) |-> o_long_call [*4] ##1 !o_long_call)
    else $error("long call length wrong");
  AST_ENTRY: assert property ($fell(o_long_call) |-> o_service_entry)
    else $error("entry not at end of call");
  AST_VECTOR: assert property ($rose(o_long_call) |-> o_vector[2:0] == 3'h3 && o_vector <= 16'h0073)
    else $error("vector off grid");
  AST_HWCLR_VAL: assert property ($rose(o_long_call) |->
    o_hw_clear == ((o_vector <= 16'h001b) ? (4'h1 << o_vector[4:3]) : 4'h0))
    else $error("hardware clear mismatch");
  AST_HWCLR_WHEN: assert property (|o_hw_clear |-> $rose(o_long_call))
    else $error("hardware clear outside call start");
  AST_LEVEL_BIT7: assert property (i_sfr.rd_en && i_sfr.addr == 8'hb8 |=> o_sfr.hit && o_sfr.rdata[7])
    else $error("level bit 7 not one");
  AST_UNMAPPED: assert property (i_sfr.rd_en && !(i_sfr.addr inside {8'ha8, 8'hb8}) |=> o_sfr == '0)
    else $error("unmapped read answered");
  AST_NO_PREEMPT: assert property ($rose(o_long_call) |-> !$past(o_active_levels[1]))
    else $error("high routine preempted");
  AST_POST_GAP: assert property (i_return_from_service ##1 !i_insn_end |=> !$rose(o_long_call))
    else $error("call without instruction after return");
  AST_ENTRY_LEVEL: assert property (o_service_entry |-> ##[0:1] o_active_levels != 2'b00)
    else $error("entry without active level");
  cover property ($rose(o_long_call) && o_active_levels == 2'b01);
  cover property (i_return_from_service ##1 !i_insn_end);
  cover property (o_service_entry && o_vector == 16'h0073);
endmodule
bind tlirq_ctrl tlirq_ctrl_properties #(.NUM_SOURCES(NUM_SOURCES), .CALL_CYCLES(CALL_CYCLES)) i_tlirq_ctrl_properties (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_sfr(i_sfr), .o_sfr(o_sfr),
  .i_return_from_service(i_return_from_service), .i_insn_end(i_insn_end), .o_long_call(o_long_call),
  .o_vector(o_vector), .o_service_entry(o_service_entry), .o_hw_clear(o_hw_clear),
  .o_active_levels(o_active_levels));

// file: tlirq_map.svh
// Register map, field positions, reset values and timing counts of the interrupt controller.
`ifndef TLIRQ_MAP_SVH
`define TLIRQ_MAP_SVH
`define TLIRQ_ADDR_MASK_ENABLE  8'ha8
`define TLIRQ_ADDR_LEVEL_SELECT 8'hb8
`define TLIRQ_RST_MASK_ENABLE   8'h00
`define TLIRQ_RST_LEVEL_SELECT  8'h80
`define TLIRQ_GATE_BIT          7
`define TLIRQ_LEVEL_FIXED_BIT   7
`define TLIRQ_BIT_BASE_MSB      7
`define TLIRQ_BIT_BASE_LSB      3
`define TLIRQ_RESET_VECTOR      16'h0000
`define TLIRQ_VECTOR_BASE       16'h0003
`define TLIRQ_VECTOR_STEP_SHIFT 3
`define TLIRQ_NUM_SOURCES       15
`define TLIRQ_NUM_HW_CLEAR      4
`define TLIRQ_DETECT_CYCLES     1
`define TLIRQ_CALL_CYCLES       4
`define TLIRQ_RETURN_CYCLES     5
`define TLIRQ_DIVIDE_CYCLES     8
`define TLIRQ_BEST_CYCLES       (`TLIRQ_DETECT_CYCLES + `TLIRQ_CALL_CYCLES)
`define TLIRQ_WORST_CYCLES      (`TLIRQ_DETECT_CYCLES + `TLIRQ_RETURN_CYCLES + `TLIRQ_DIVIDE_CYCLES + `TLIRQ_CALL_CYCLES)
`endif

// file: tlirq_pkg.sv
// Types shared by the interrupt controller files.
package tlirq_pkg;

  // Pending flags as the peripherals present them, one bit per flag.
  typedef struct packed {
    logic [7:0] extended;
    logic       serial_periph;
    logic       timer_two_high_overflow;
    logic       timer_two_low_overflow;
    logic       async_serial;
    logic       timer_one;
    logic       ext_pin_one;
    logic       timer_zero;
    logic       ext_pin_zero;
  } tlirq_flags_t;

  // Register access from the core's special function register port.
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr_en;
    logic [7:0] bit_addr;
    logic       bit_val;
  } tlirq_sfr_req_t;

  typedef struct packed {
    logic       hit;
    logic [7:0] rdata;
  } tlirq_sfr_rsp_t;

  typedef enum logic [1:0] {
    TLIRQ_IDLE = 2'b00,
    TLIRQ_CALL = 2'b01,
    TLIRQ_POST = 2'b11
  } tlirq_state_t;

endpackage
